// ===== core/i2c_target_pkg.sv
package i2c_target_pkg;

   // Core clock
   localparam int          CLK_PERIOD_NS      = 20;

   // Register offsets
   localparam logic [7:0]  OFS_DEVICE_STATUS  = 8'h00;
   localparam logic [7:0]  OFS_GENERAL_CONFIG = 8'h01;
   localparam logic [7:0]  OFS_OUTPUT_DATA    = 8'h02;
   localparam logic [7:0]  OFS_AVG_RATIO      = 8'h03;
   localparam logic [7:0]  OFS_OP_MODE        = 8'h04;
   localparam logic [7:0]  OFS_CHAN_FUNC      = 8'h05;
   localparam logic [7:0]  OFS_DIG_DIRECTION  = 8'h07;
   localparam logic [7:0]  OFS_DRIVE_TYPE     = 8'h09;
   localparam logic [7:0]  OFS_DIG_OUT_LEVELS = 8'h0B;
   localparam logic [7:0]  OFS_DIG_IN_LEVELS  = 8'h0D;
   localparam logic [7:0]  OFS_SEQ_CONFIG     = 8'h10;
   localparam logic [7:0]  OFS_MANUAL_CHAN    = 8'h11;
   localparam logic [7:0]  OFS_SEQ_CHAN_EN    = 8'h12;
   localparam int          REG_IDX_W          = 5;
   localparam int          REG_SPAN           = 32;

   // Reset values and field positions
   localparam logic [7:0]  STATUS_RESET       = 8'h80;
   localparam logic [7:0]  DEFAULT_RESET      = 8'h00;
   localparam int          STATUS_HS_BIT      = 6;
   localparam int          GEN_RST_BIT        = 0;

   // Command opcodes
   localparam logic [7:0]  OP_READ_ONE        = 8'h10;
   localparam logic [7:0]  OP_WRITE_ONE       = 8'h08;
   localparam logic [7:0]  OP_SET_BITS        = 8'h18;
   localparam logic [7:0]  OP_CLEAR_BITS      = 8'h20;
   localparam logic [7:0]  OP_READ_BLOCK      = 8'h30;
   localparam logic [7:0]  OP_WRITE_BLOCK     = 8'h28;

   // General call and high-speed entry codes
   localparam logic [7:0]  GC_ADDR_BYTE       = 8'h00;
   localparam logic [7:0]  GC_SOFT_RESET      = 8'h06;
   localparam logic [7:0]  GC_ADDR_EVAL       = 8'h04;
   localparam logic [7:0]  HS_CODE_MASK       = 8'hF9;
   localparam logic [7:0]  HS_CODE_MATCH      = 8'h09;

   // Own address: upper bits fixed (arbitrary value), low three from strap
   localparam logic [6:0]  TARGET_ADDR_BASE   = 7'h10;
   localparam int          ADDR_EVAL_NS       = 200;
   localparam int          ADDR_EVAL_CYC      = (ADDR_EVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef struct packed {
      logic [7:0] general_configuration;
      logic [7:0] output_data_configuration;
      logic [7:0] averaging_ratio_config;
      logic [7:0] operating_mode_config;
      logic [7:0] channel_function_select;
      logic [7:0] digital_direction_config;
      logic [7:0] output_drive_type_config;
      logic [7:0] digital_output_levels;
      logic [7:0] sequencer_configuration;
      logic [7:0] manual_channel_select;
      logic [7:0] sequence_channel_enables;
   } cfg_t;

   function automatic logic reg_mapped(input logic [7:0] a);
      case (a)
         OFS_DEVICE_STATUS, OFS_GENERAL_CONFIG, OFS_OUTPUT_DATA, OFS_AVG_RATIO,
         OFS_OP_MODE, OFS_CHAN_FUNC, OFS_DIG_DIRECTION, OFS_DRIVE_TYPE,
         OFS_DIG_OUT_LEVELS, OFS_DIG_IN_LEVELS, OFS_SEQ_CONFIG, OFS_MANUAL_CHAN,
         OFS_SEQ_CHAN_EN: reg_mapped = 1'b1;
         default:         reg_mapped = 1'b0;
      endcase
   endfunction

   function automatic logic reg_writable(input logic [7:0] a);
      reg_writable = reg_mapped(a) && (a != OFS_DIG_IN_LEVELS) && (a != OFS_DEVICE_STATUS);
   endfunction

   function automatic logic [7:0] reg_reset(input logic [7:0] a);
      reg_reset = (a == OFS_DEVICE_STATUS) ? STATUS_RESET : DEFAULT_RESET;
   endfunction

endpackage

// ===== core/i2c_line_events.sv
`timescale 1ns/10ps
`default_nettype none
module i2c_line_events
   import i2c_target_pkg::*;
(
   input  wire logic i_clk,
   input  wire logic i_rst_b,
   input  wire logic i_scl,
   input  wire logic i_sda,
   output logic      o_sda_q,
   output logic      o_scl_rise,
   output logic      o_scl_fall,
   output logic      o_start,
   output logic      o_stop
);
   logic scl_reg;
   logic sda_reg;

   // Previous line levels; idle bus is high
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         scl_reg <= 1'b1;
         sda_reg <= 1'b1;
      end else begin
         scl_reg <= i_scl;
         sda_reg <= i_sda;
      end
   end

   // Edges and bus conditions; SDA moving while SCL high marks start/stop
   assign o_sda_q    = sda_reg;
   assign o_scl_rise = i_scl & ~scl_reg;
   assign o_scl_fall = ~i_scl & scl_reg;
   assign o_start    = i_scl & scl_reg & sda_reg & ~i_sda;
   assign o_stop     = i_scl & scl_reg & ~sda_reg & i_sda;
endmodule
`default_nettype wire

// ===== core/reg_store.sv
`timescale 1ns/10ps
`default_nettype none
module reg_store
   import i2c_target_pkg::*;
(
   input  wire logic       i_clk,
   input  wire logic       i_rst_b,
   input  wire logic       i_soft_rst,
   input  wire logic [7:0] i_raddr,
   input  wire logic       i_we,
   input  wire logic [7:0] i_waddr,
   input  wire logic [7:0] i_wdata,
   output logic      [7:0] o_rdata,
   output cfg_t            o_cfg
);
   logic [7:0] mem_reg [0:REG_SPAN-1];

   // Storage; reserved and read-only offsets never change
   // [R12] unmapped offsets ignored
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         for (int i = 0; i < REG_SPAN; i++) begin
            mem_reg[i] <= reg_reset(8'(i));
         end
      end else if (i_soft_rst) begin
         for (int i = 0; i < REG_SPAN; i++) begin
            mem_reg[i] <= reg_reset(8'(i));
         end
      end else if (i_we && reg_writable(i_waddr)) begin
         mem_reg[i_waddr[REG_IDX_W-1:0]] <= i_wdata;
      end
   end

   // Registered read; unmapped offsets read zero
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_rdata <= 8'h00;
      end else begin
         o_rdata <= reg_mapped(i_raddr) ? mem_reg[i_raddr[REG_IDX_W-1:0]] : 8'h00;
      end
   end

   // Configuration seen by the rest of the device
   assign o_cfg.general_configuration     = mem_reg[OFS_GENERAL_CONFIG[REG_IDX_W-1:0]];
   assign o_cfg.output_data_configuration = mem_reg[OFS_OUTPUT_DATA[REG_IDX_W-1:0]];
   assign o_cfg.averaging_ratio_config    = mem_reg[OFS_AVG_RATIO[REG_IDX_W-1:0]];
   assign o_cfg.operating_mode_config     = mem_reg[OFS_OP_MODE[REG_IDX_W-1:0]];
   assign o_cfg.channel_function_select   = mem_reg[OFS_CHAN_FUNC[REG_IDX_W-1:0]];
   assign o_cfg.digital_direction_config  = mem_reg[OFS_DIG_DIRECTION[REG_IDX_W-1:0]];
   assign o_cfg.output_drive_type_config  = mem_reg[OFS_DRIVE_TYPE[REG_IDX_W-1:0]];
   assign o_cfg.digital_output_levels     = mem_reg[OFS_DIG_OUT_LEVELS[REG_IDX_W-1:0]];
   assign o_cfg.sequencer_configuration   = mem_reg[OFS_SEQ_CONFIG[REG_IDX_W-1:0]];
   assign o_cfg.manual_channel_select     = mem_reg[OFS_MANUAL_CHAN[REG_IDX_W-1:0]];
   assign o_cfg.sequence_channel_enables  = mem_reg[OFS_SEQ_CHAN_EN[REG_IDX_W-1:0]];
endmodule
`default_nettype wire

// ===== core/i2c_register_access_target.sv
// Overview of operation
// [R1] Host selects a read register by address, read opcode, register address frames.
// [R2] After a read address frame the device shifts out the selected register.
// [R3] Single read repeats the same register byte for every extra byte clocked.
// [R4] Host ends each read with STOP or repeated START.
// [R5] Block read starts at the set address and advances one register per byte.
// [R6] Reads of offsets outside the map return zero.
// [R7] Block read past the last register keeps returning zero bytes.
// [R8] Single write is address, opcode, register address, data; data is stored.
// [R9] Set-bit command forces ones where the data byte has ones.
// [R10] Clear-bit command forces zeros where the data byte has ones.
// [R11] Block write stores each data byte at the next ascending address.
// [R12] Block-write bytes to unmapped offsets are acknowledged but change nothing.
// [R13] Block-write bytes beyond the address space are discarded.
// [R14] Host ends every write-type command with STOP or repeated START.
// [R15] Host should not write reserved offsets.
// [R16] Reset gives status 0x80 and zero in all other registers.
// [R17] General call is acknowledged; followed by 06h it resets the device.
// [R18] General call plus 04h re-reads own address; only general call answered meanwhile.
// [R19] Codes 09h/0Bh/0Dh/0Fh enter high-speed mode and flag it until STOP.
// [R20] First byte after write address is an opcode; unknown ones are refused.
`timescale 1ns/10ps
`default_nettype none
module i2c_register_access_target
   import i2c_target_pkg::*;
(
   input  wire logic       i_clk,
   input  wire logic       i_rst_b,
   input  wire logic       i_scl,
   input  wire logic       i_sda,
   input  wire logic [2:0] i_addr_sel,
   input  wire logic [7:0] i_dig_in_levels,
   output logic            o_sda_out,
   output logic            o_sda_oe,
   output logic            o_hs_mode,
   output cfg_t            o_cfg
);
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RX,
      ST_RX_ACK,
      ST_TX,
      ST_TX_ACK,
      ST_WAIT
   } state_t;

   state_t      state_reg;
   logic [3:0]  bit_cnt_reg;
   logic [7:0]  shift_reg;
   logic [1:0]  byte_cnt_reg;
   logic        is_read_reg;
   logic        is_gc_reg;
   logic [7:0]  opcode_reg;
   logic        rd_block_reg;
   logic        wr_done_reg;
   logic [7:0]  ptr_reg;
   logic        ptr_over_reg;
   logic [7:0]  tx_reg;
   logic        hs_reg;
   logic        oe_reg;
   logic        soft_rst_reg;
   logic [6:0]  own_addr_reg;
   logic [3:0]  eval_cnt_reg;
   logic        master_nack_reg;

   logic        sda_q;
   logic        scl_rise;
   logic        scl_fall;
   logic        start_cond;
   logic        stop_cond;
   logic [7:0]  rdata;
   logic [7:0]  rd_byte;
   logic [7:0]  wr_data;
   logic        wr_en;
   logic        rx_done;
   logic        byte_ack;
   logic        addr_busy;
   logic        op_known;
   logic        op_is_write;

   i2c_line_events u_events (
      .i_clk      (i_clk),
      .i_rst_b    (i_rst_b),
      .i_scl      (i_scl),
      .i_sda      (i_sda),
      .o_sda_q    (sda_q),
      .o_scl_rise (scl_rise),
      .o_scl_fall (scl_fall),
      .o_start    (start_cond),
      .o_stop     (stop_cond)
   );

   reg_store u_regs (
      .i_clk      (i_clk),
      .i_rst_b    (i_rst_b),
      .i_soft_rst (soft_rst_reg),
      .i_raddr    (ptr_reg),
      .i_we       (wr_en),
      .i_waddr    (ptr_reg),
      .i_wdata    (wr_data),
      .o_rdata    (rdata),
      .o_cfg      (o_cfg)
   );

   // Opcode classes
   assign op_known    = (opcode_reg == OP_READ_ONE) || (opcode_reg == OP_READ_BLOCK) ||
                        op_is_write;
   assign op_is_write = (opcode_reg == OP_WRITE_ONE) || (opcode_reg == OP_SET_BITS) ||
                        (opcode_reg == OP_CLEAR_BITS) || (opcode_reg == OP_WRITE_BLOCK);

   // Eighth bit finished on the falling clock edge
   assign rx_done   = (state_reg == ST_RX) && scl_fall && (bit_cnt_reg == 4'd8);
   assign addr_busy = (eval_cnt_reg != 4'd0);

   // Acknowledge decision for the byte just received
   always_comb begin
      byte_ack = 1'b0;
      case (byte_cnt_reg)
         2'd0: begin
            // [R17] general call acked
            if (shift_reg == GC_ADDR_BYTE) begin
               byte_ack = 1'b1;
            // [R18] own address ignored while re-evaluating
            end else if (!addr_busy && (shift_reg[7:1] == own_addr_reg)) begin
               byte_ack = 1'b1;
            end
         end
         2'd1: begin
            // [R20] unknown opcode refused
            byte_ack = is_gc_reg ||
                       (shift_reg == OP_READ_ONE) || (shift_reg == OP_READ_BLOCK) ||
                       (shift_reg == OP_WRITE_ONE) || (shift_reg == OP_SET_BITS) ||
                       (shift_reg == OP_CLEAR_BITS) || (shift_reg == OP_WRITE_BLOCK);
         end
         default: begin
            byte_ack = !is_gc_reg;
         end
      endcase
   end

   // Bus-level sequencing; start and stop override everything
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state_reg   <= ST_IDLE;
         bit_cnt_reg <= 4'd0;
      end else if (start_cond) begin
         state_reg   <= ST_RX;
         bit_cnt_reg <= 4'd0;
      end else if (stop_cond) begin
         state_reg   <= ST_IDLE;
         bit_cnt_reg <= 4'd0;
      end else begin
         case (state_reg)
            ST_RX: begin
               if (scl_rise) begin
                  bit_cnt_reg <= bit_cnt_reg + 4'd1;
               end else if (rx_done) begin
                  state_reg   <= byte_ack ? ST_RX_ACK : ST_WAIT;
                  bit_cnt_reg <= 4'd0;
               end
            end
            ST_RX_ACK: begin
               if (scl_fall) begin
                  // [R2] read address frame turns the bus round
                  state_reg <= (is_read_reg && (byte_cnt_reg == 2'd1)) ? ST_TX : ST_RX;
               end
            end
            ST_TX: begin
               if (scl_fall) begin
                  if (bit_cnt_reg == 4'd7) begin
                     state_reg   <= ST_TX_ACK;
                     bit_cnt_reg <= 4'd0;
                  end else begin
                     bit_cnt_reg <= bit_cnt_reg + 4'd1;
                  end
               end
            end
            ST_TX_ACK: begin
               if (scl_fall) begin
                  state_reg <= master_nack_reg ? ST_WAIT : ST_TX;
               end
            end
            ST_IDLE, ST_WAIT: begin
               bit_cnt_reg <= 4'd0;
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // Receive shifter
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         shift_reg <= 8'h00;
      end else if ((state_reg == ST_RX) && scl_rise) begin
         shift_reg <= {shift_reg[6:0], sda_q};
      end
   end

   // Frame position and transaction kind; repeated start keeps the pointer
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         byte_cnt_reg <= 2'd0;
         is_read_reg  <= 1'b0;
         is_gc_reg    <= 1'b0;
         opcode_reg   <= 8'h00;
         wr_done_reg  <= 1'b0;
      end else if (start_cond) begin
         byte_cnt_reg <= 2'd0;
         is_read_reg  <= 1'b0;
         is_gc_reg    <= 1'b0;
         wr_done_reg  <= 1'b0;
      end else if (rx_done && byte_ack) begin
         if (byte_cnt_reg != 2'd3) begin
            byte_cnt_reg <= byte_cnt_reg + 2'd1;
         end
         if (byte_cnt_reg == 2'd0) begin
            is_read_reg <= shift_reg[0];
            is_gc_reg   <= (shift_reg == GC_ADDR_BYTE);
         end
         if ((byte_cnt_reg == 2'd1) && !is_gc_reg) begin
            opcode_reg <= shift_reg;
         end
         if (byte_cnt_reg == 2'd3) begin
            wr_done_reg <= 1'b1;
         end
      end
   end

   // Data byte store; single commands act once, block write every byte
   always_comb begin
      wr_en = rx_done && (byte_cnt_reg == 2'd3) && !is_gc_reg && op_is_write && !ptr_over_reg;
      if ((opcode_reg != OP_WRITE_BLOCK) && wr_done_reg) begin
         wr_en = 1'b0;
      end
      case (opcode_reg)
         // [R9] set selected bits
         OP_SET_BITS:   wr_data = rdata | shift_reg;
         // [R10] clear selected bits
         OP_CLEAR_BITS: wr_data = rdata & ~shift_reg;
         // [R8] plain store
         default:       wr_data = shift_reg;
      endcase
   end

   // Register pointer
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ptr_reg      <= 8'h00;
         ptr_over_reg <= 1'b0;
         rd_block_reg <= 1'b0;
      end else if (rx_done && byte_ack && (byte_cnt_reg == 2'd2) && !is_gc_reg) begin
         // [R1] address frame after a read opcode sets the pointer
         ptr_reg      <= shift_reg;
         ptr_over_reg <= 1'b0;
         rd_block_reg <= (opcode_reg == OP_READ_BLOCK);
      end else if (rx_done && (byte_cnt_reg == 2'd3) && (opcode_reg == OP_WRITE_BLOCK) &&
                   !is_gc_reg && !ptr_over_reg) begin
         // [R11] block write advances; [R13] stops at the top of the space
         {ptr_over_reg, ptr_reg} <= {1'b0, ptr_reg} + 9'd1;
      end else if ((state_reg == ST_TX_ACK) && scl_rise && !sda_q && rd_block_reg &&
                   !ptr_over_reg) begin
         // [R5] block read advances on host acknowledge; [R3] single read stays
         {ptr_over_reg, ptr_reg} <= {1'b0, ptr_reg} + 9'd1;
      end
   end

   // Outgoing byte: unmapped reads zero from the store, overflow reads zero
   always_comb begin
      if (ptr_over_reg) begin
         // [R7] past the last register
         rd_byte = 8'h00;
      end else if (ptr_reg == OFS_DIG_IN_LEVELS) begin
         rd_byte = i_dig_in_levels;
      end else if (ptr_reg == OFS_DEVICE_STATUS) begin
         rd_byte = rdata | (hs_reg ? (8'h01 << STATUS_HS_BIT) : 8'h00);
      end else begin
         // [R6] store returns zero for unmapped offsets
         rd_byte = rdata;
      end
   end

   // Transmit shifter; reloads at each byte boundary
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         tx_reg <= 8'hFF;
      end else if (scl_fall && ((state_reg == ST_RX_ACK) || (state_reg == ST_TX_ACK))) begin
         // [R2] selected register shifted out
         tx_reg <= rd_byte;
      end else if (scl_fall && (state_reg == ST_TX)) begin
         tx_reg <= {tx_reg[6:0], 1'b1};
      end
   end

   // Host acknowledge sampled on its clock high
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         master_nack_reg <= 1'b0;
      end else if ((state_reg == ST_TX_ACK) && scl_rise) begin
         master_nack_reg <= sda_q;
      end
   end

   // Open-drain drive, one clock behind the state for a clean flop output
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         oe_reg <= 1'b0;
      end else begin
         oe_reg <= (state_reg == ST_RX_ACK) || ((state_reg == ST_TX) && !tx_reg[7]);
      end
   end

   // Soft reset pulse: general call 06h or the reset bit in general config
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         soft_rst_reg <= 1'b0;
      end else begin
         // [R17] general call reset
         soft_rst_reg <= (rx_done && is_gc_reg && (byte_cnt_reg == 2'd1) &&
                          (shift_reg == GC_SOFT_RESET)) ||
                         (wr_en && (ptr_reg == OFS_GENERAL_CONFIG) && wr_data[GEN_RST_BIT]);
      end
   end

   // High-speed flag; a stop clears it, entry on a master code
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         hs_reg <= 1'b0;
      end else if (rx_done && (byte_cnt_reg == 2'd0) &&
                   ((shift_reg & HS_CODE_MASK) == HS_CODE_MATCH)) begin
         // [R19] enter high-speed mode
         hs_reg <= 1'b1;
      end else if (stop_cond) begin
         hs_reg <= 1'b0;
      end
   end

   // Own address from the strap, caught after reset release and on request
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         eval_cnt_reg <= 4'(ADDR_EVAL_CYC);
         own_addr_reg <= TARGET_ADDR_BASE;
      end else if (rx_done && is_gc_reg && (byte_cnt_reg == 2'd1) &&
                   (shift_reg == GC_ADDR_EVAL)) begin
         // [R18] restart address evaluation
         eval_cnt_reg <= 4'(ADDR_EVAL_CYC);
      end else if (addr_busy) begin
         eval_cnt_reg <= eval_cnt_reg - 4'd1;
         if (eval_cnt_reg == 4'd1) begin
            own_addr_reg <= {TARGET_ADDR_BASE[6:3], i_addr_sel};
         end
      end
   end

   // Line is only ever pulled low
   assign o_sda_out = 1'b0;
   assign o_sda_oe  = oe_reg;
   assign o_hs_mode = hs_reg;
   // [R16] status reset value lives in the store; reserved offsets stay zero
endmodule
`default_nettype wire

// ===== test/i2c_target_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module i2c_target_assertions
   import i2c_target_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic o_sda_out,
   input wire logic o_sda_oe,
   input wire logic o_hs_mode,
   input wire cfg_t o_cfg
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   // Bus side: device touches SDA only while SCL is low
   sda_low_only_a: assert property (o_sda_out == 1'b0)
      else $error("sda output not low");
   oe_scl_low_a: assert property ($changed(o_sda_oe) |-> !i_scl)
      else $error("sda drive changed with scl high");
   bit_hold_a: assert property (o_sda_oe && i_scl |=> o_sda_oe)
      else $error("sda released during scl high");
   ack_delay_a: assert property ($rose(o_sda_oe) |-> !$past(i_scl) && !$past(i_scl, 2))
      else $error("sda drive too soon after scl fall");
   cfg_update_a: assert property ($changed(o_cfg) |-> !i_scl && !$past(i_scl))
      else $error("register changed outside scl low");
   // High-speed flag set on a byte, cleared only by a stop
   hs_set_low_a: assert property ($rose(o_hs_mode) |-> !i_scl)
      else $error("hs flag set with scl high");
   hs_clear_high_a: assert property ($fell(o_hs_mode) |-> i_scl)
      else $error("hs flag cleared without stop");
   hs_stop_clear_a: assert property ($rose(i_sda) && i_scl && $past(i_scl) |-> ##[1:6] !o_hs_mode)
      else $error("hs flag kept after stop");
   cover property ($rose(o_hs_mode));
   cover property ($rose(o_sda_oe));
   cover property ($changed(o_cfg));
endmodule
`default_nettype wire

// ===== test/i2c_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module i2c_host_model (
   input  wire logic i_clk,
   input  wire logic i_dut_oe,
   output logic      o_scl,
   output logic      o_sda
);
   logic host_oe = 1'b0;
   // Pull-up: a released line reads high
   assign o_sda = ~(host_oe | i_dut_oe);
   initial o_scl = 1'b1;
   // Step just past the edge, keeps both SCL phases well above 3 clocks
   task automatic hw(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   task automatic start();
      host_oe = 1'b0;
      hw(4);
      o_scl = 1'b1;
      hw(4);
      host_oe = 1'b1;
      hw(4);
      o_scl = 1'b0;
      hw(1);
   endtask
   // One bit, sampled mid high phase
   task automatic bit_io(input logic b, output logic r);
      host_oe = ~b;
      hw(4);
      o_scl = 1'b1;
      hw(2);
      r = o_sda;
      hw(2);
      o_scl = 1'b0;
      hw(1);
   endtask
   task automatic xfer(input logic [7:0] d, input logic ack, output logic [8:0] r);
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], r[i+1]);
      bit_io(ack, r[0]);
   endtask
   task automatic stop();
      host_oe = 1'b1;
      hw(4);
      o_scl = 1'b1;
      hw(4);
      host_oe = 1'b0;
      hw(8);
   endtask
endmodule
`default_nettype wire

// ===== test/i2c_register_access_target_test.sv
`timescale 1ns/10ps
`default_nettype none
module i2c_register_access_target_test
   import i2c_target_pkg::*;
;
   typedef struct packed {
      logic [7:0] op;
      logic [7:0] ad;
      logic [7:0] dt;
      logic [7:0] ex;
   } row_t;
   localparam logic [7:0] AW  = {TARGET_ADDR_BASE[6:3], 3'h5, 1'b0};
   localparam logic [7:0] DIN = 8'hC3;
   logic       clk   = 1'b0;
   logic       rst_b = 1'b0;
   logic       scl;
   logic       sda;
   logic       sda_oe;
   logic [2:0] asel  = 3'h5;
   logic       hs;
   cfg_t       cfg;
   logic [8:0] rb;
   int         fails     = 0;
   int         cmp_count = 0;
   // Write-type command, then read back expectation
   // reserved offsets are touched only in the rows meant to prove they ignore writes
   row_t       rows [8]  = '{'{OP_WRITE_ONE, 8'h02, 8'h55, 8'h55}, '{OP_SET_BITS, 8'h02, 8'h0A, 8'h5F},
      '{OP_CLEAR_BITS, 8'h02, 8'h11, 8'h4E}, '{OP_WRITE_ONE, 8'h06, 8'hAA, 8'h00},
      '{OP_WRITE_ONE, 8'h0D, 8'h33, DIN}, '{OP_WRITE_ONE, 8'h00, 8'h12, 8'h80},
      '{8'h77, 8'h03, 8'h99, 8'h00}, '{OP_SET_BITS, 8'h12, 8'hFF, 8'hFF}};
   always #(CLK_PERIOD_NS / 2) clk = ~clk;
   i2c_register_access_target u_dut (.i_clk(clk), .i_rst_b(rst_b), .i_scl(scl), .i_sda(sda),
      .i_addr_sel(asel), .i_dig_in_levels(DIN), .o_sda_out(), .o_sda_oe(sda_oe), .o_hs_mode(hs), .o_cfg(cfg));
   i2c_host_model u_host (.i_clk(clk), .i_dut_oe(sda_oe), .o_scl(scl), .o_sda(sda));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Command with n data bytes taken from the top of d
   task automatic wr(input logic [7:0] op, input logic [7:0] a, input int n, input logic [31:0] d);
      u_host.start();
      u_host.xfer(AW, 1'b1, rb);
      u_host.xfer(op, 1'b1, rb);
      u_host.xfer(a, 1'b1, rb);
      for (int i = 0; i < n; i++)
         u_host.xfer(d[31-8*i -: 8], 1'b1, rb);
      u_host.stop();
   endtask
   // Set pointer, repeated start, n bytes; last one answered with NACK
   task automatic rd(input logic [7:0] op, input logic [7:0] a, input int n, input logic [31:0] e);
      u_host.start();
      u_host.xfer(AW, 1'b1, rb);
      u_host.xfer(op, 1'b1, rb);
      u_host.xfer(a, 1'b1, rb);
      u_host.start();
      u_host.xfer(AW | 8'h01, 1'b1, rb);
      for (int i = 0; i < n; i++) begin
         u_host.xfer(8'hFF, i == n - 1, rb);
         chk(rb[8:1], e[31-8*i -: 8]);
      end
      u_host.stop();
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic boot();
      repeat (12) @(posedge clk);
      #1 rst_b = 1'b1;
      repeat (ADDR_EVAL_CYC + 2) @(posedge clk);
      #1;
   endtask
   // Watchdog, about five times the expected run
   initial begin
      #1_500_000;
      fails++;
      results();
   end
   initial begin
      boot();
      foreach (rows[k]) begin
         wr(rows[k].op, rows[k].ad, 1, {rows[k].dt, 24'h0});
         rd(OP_READ_ONE, rows[k].ad, 1, {rows[k].ex, 24'h0});
      end
      $display("row tests done");
      rd(OP_READ_ONE, 8'h02, 3, 32'h4E4E4E00);
      wr(OP_WRITE_BLOCK, 8'h10, 4, 32'h01020304);
      rd(OP_READ_BLOCK, 8'h10, 4, 32'h01020300);
      wr(OP_WRITE_BLOCK, 8'hFE, 4, 32'h0B0C005A);
      chk(cfg.general_configuration, 8'h00);
      rd(OP_READ_BLOCK, 8'hFF, 2, 32'h0);
      $display("block tests done");
      // Every high-speed code, flag seen in status bit 6 until stop
      for (int k = 0; k < 4; k++) begin
         u_host.start();
         u_host.xfer(8'h09 + 8'(k * 2), 1'b1, rb);
         chk({7'h0, hs}, 8'h01);
         rd(OP_READ_ONE, 8'h00, 1, 32'hC0000000);
         chk({7'h0, hs}, 8'h00);
      end
      $display("high speed tests done");
      wr(OP_WRITE_ONE, 8'h03, 1, 32'h77000000);
      rd(OP_READ_ONE, 8'h03, 1, 32'h77000000);
      u_host.start();
      u_host.xfer(8'h00, 1'b1, rb);
      chk({7'h0, rb[0]}, 8'h00);
      u_host.xfer(8'h06, 1'b1, rb);
      u_host.stop();
      chk(cfg.averaging_ratio_config, 8'h00);
      $display("general call test done");
      // Strap moved; general call 04h must re-read the own address
      asel = 3'h2;
      u_host.start();
      u_host.xfer(GC_ADDR_BYTE, 1'b1, rb);
      u_host.xfer(GC_ADDR_EVAL, 1'b1, rb);
      u_host.start();
      u_host.xfer(AW, 1'b1, rb);
      chk({7'h0, rb[0]}, 8'h01);
      u_host.start();
      u_host.xfer({AW[7:4], 3'h2, 1'b0}, 1'b1, rb);
      chk({7'h0, rb[0]}, 8'h00);
      u_host.stop();
      asel = 3'h5;
      $display("address test done");
      // Second reset in mid-run
      rst_b = 1'b0;
      boot();
      rd(OP_READ_BLOCK, 8'h00, 4, 32'h80000000);
      rd(OP_READ_BLOCK, 8'h10, 3, 32'h0);
      $display("reset test done");
      results();
   end
endmodule
bind i2c_register_access_target i2c_target_assertions u_chk (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_scl(i_scl),
   .i_sda(i_sda), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_hs_mode(o_hs_mode), .o_cfg(o_cfg));
`default_nettype wire
